// *** rtl/ssc_pkg.sv ***
// Shared constants and types for the store, stack and control executor
package ssc_pkg;
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 8;
  localparam int          IO_AW       = 6;
  localparam int          REG_IW      = 4;
  localparam int          LOCK_W      = 2;
  localparam int          FLASH_AW    = 9;
  localparam logic [15:0] PTR_RESET   = 16'h0000;
  localparam logic [15:0] SP_RESET    = 16'h005F;
  localparam logic [1:0]  LOCK_RESET  = 2'h0;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS   = 16'hB400;
  localparam logic [1:0]  PSEL_Y      = 2'h0;
  localparam logic [1:0]  PSEL_Z      = 2'h1;
  localparam logic [1:0]  PSEL_SP     = 2'h2;
  localparam int          CYC_STORE   = 2;
  localparam int          CYC_SINGLE  = 1;

  typedef enum logic [3:0] {
    SSC_OP_IDLE_OP,
    SSC_OP_WR_IND,
    SSC_OP_WR_POSTINC,
    SSC_OP_WR_PREDEC,
    SSC_OP_WR_DIRECT,
    SSC_OP_IO_READ,
    SSC_OP_IO_WRITE,
    SSC_OP_PUSH,
    SSC_OP_POP,
    SSC_OP_SLEEP,
    SSC_OP_WDOG_RESTART,
    SSC_OP_DBG_BREAK
  } ssc_op_t;

  typedef enum logic {
    SSC_PH_READY,
    SSC_PH_HOLD
  } ssc_state_t;
endpackage : ssc_pkg

// *** rtl/ssc_exec.sv ***
// Executor for indirect/direct stores, I/O access, stack and control ops
//
// Functional notes
// (RULE1) Post-increment store via Y or Z writes, then increments; 2 cycles.
// (RULE2) Pre-decrement store via Y or Z decrements, then writes; 2 cycles.
// (RULE3) Direct store writes source_reg at the constant address in 2 cycles.
// (RULE4) I/O read loads a register, I/O write stores one; 1 cycle each.
// (RULE5) Push puts source_reg on the stack in 2 cycles, flags untouched.
// (RULE6) Pop loads a register from the stack in 2 cycles, flags untouched.
// (RULE7) Sleep takes 1 cycle, flags untouched, and requests the sleep logic.
// (RULE8) Watchdog restart takes 1 cycle, flags untouched, pulsing the timer.
// (RULE9) Debug break only signals the on-chip debugger; no cycle count.
// (RULE10) Lock writes not above the current mode corrupt a random flash word.
// (RULE11) The external programmer must only ever raise the lock mode.
// (RULE12) Plain store via Y or Z writes at the pointer, leaving it; 2 cycles.
// (RULE13) The idle_op takes one cycle and changes nothing.
`timescale 1ns/1ps
module ssc_exec #(
  parameter int FLASH_AW = ssc_pkg::FLASH_AW
) (
  input  wire logic                          clock_i,
  input  wire logic                          srst_i,
  input  wire logic                          op_valid_i,
  input  wire ssc_pkg::ssc_op_t              op_code_i,
  input  wire logic                          op_ptr_z_i,
  input  wire logic [ssc_pkg::REG_IW-1:0]    op_reg_i,
  input  wire logic [ssc_pkg::ADDR_W-1:0]    op_addr_i,
  input  wire logic [ssc_pkg::DATA_W-1:0]    source_reg_i,
  input  wire logic [ssc_pkg::DATA_W-1:0]    mem_rdata_i,
  input  wire logic [ssc_pkg::DATA_W-1:0]    io_rdata_i,
  input  wire logic                          ptr_load_i,
  input  wire logic [1:0]                    ptr_load_sel_i,
  input  wire logic [ssc_pkg::ADDR_W-1:0]    ptr_load_val_i,
  input  wire logic                          lock_wr_i,
  input  wire logic [ssc_pkg::LOCK_W-1:0]    lock_mode_i,
  output logic                               busy_o,
  output logic                               mem_we_o,
  output logic                               mem_re_o,
  output logic [ssc_pkg::ADDR_W-1:0]         mem_addr_o,
  output logic [ssc_pkg::DATA_W-1:0]         mem_wdata_o,
  output logic                               io_we_o,
  output logic                               io_re_o,
  output logic [ssc_pkg::IO_AW-1:0]          io_addr_o,
  output logic [ssc_pkg::DATA_W-1:0]         io_wdata_o,
  output logic                               rd_we_o,
  output logic [ssc_pkg::REG_IW-1:0]         rd_idx_o,
  output logic [ssc_pkg::DATA_W-1:0]         rd_data_o,
  output logic [ssc_pkg::ADDR_W-1:0]         ptr_y_o,
  output logic [ssc_pkg::ADDR_W-1:0]         ptr_z_o,
  output logic [ssc_pkg::ADDR_W-1:0]         sp_o,
  output logic                               sleep_req_o,
  output logic                               watchdog_restart_o,
  output logic                               dbg_break_o,
  output logic [ssc_pkg::LOCK_W-1:0]         lock_mode_o,
  output logic                               flash_corrupt_o,
  output logic [FLASH_AW-1:0]                flash_corrupt_addr_o
);

  if (FLASH_AW < 1 || FLASH_AW > 16) begin : g_chk
    $error("FLASH_AW must lie between 1 and 16");
  end

  typedef struct packed {
    ssc_pkg::ssc_state_t             phase;
    logic                            busy;
    logic                            hold_wr;
    logic                            hold_rd;
    logic [ssc_pkg::ADDR_W-1:0]      hold_addr;
    logic [ssc_pkg::DATA_W-1:0]      hold_data;
    logic [ssc_pkg::REG_IW-1:0]      hold_idx;
    logic [ssc_pkg::ADDR_W-1:0]      ptr_y;
    logic [ssc_pkg::ADDR_W-1:0]      ptr_z;
    logic [ssc_pkg::ADDR_W-1:0]      sp;
    logic                            mem_we;
    logic                            mem_re;
    logic [ssc_pkg::ADDR_W-1:0]      mem_addr;
    logic [ssc_pkg::DATA_W-1:0]      mem_wdata;
    logic [ssc_pkg::REG_IW-1:0]      pop_idx;
    logic                            io_we;
    logic                            io_re;
    logic [ssc_pkg::IO_AW-1:0]       io_addr;
    logic [ssc_pkg::DATA_W-1:0]      io_wdata;
    logic [ssc_pkg::REG_IW-1:0]      io_idx;
    logic                            rd_we;
    logic [ssc_pkg::REG_IW-1:0]      rd_idx;
    logic [ssc_pkg::DATA_W-1:0]      rd_data;
    logic                            sleep;
    logic                            wdog;
    logic                            brk;
    logic [ssc_pkg::LOCK_W-1:0]      lock;
    logic [15:0]                     lfsr;
    logic                            corrupt;
    logic [FLASH_AW-1:0]             corrupt_addr;
  } ssc_regs_t;

  ssc_regs_t state_r;
  ssc_regs_t state_nxt;

  always_comb begin
    logic                       take;
    logic [ssc_pkg::ADDR_W-1:0] ptr;
    state_nxt = state_r;
    take      = op_valid_i && !state_r.busy;
    ptr       = op_ptr_z_i ? state_r.ptr_z : state_r.ptr_y;

    // Strobes last one cycle
    state_nxt.mem_we  = 1'b0;
    state_nxt.mem_re  = 1'b0;
    state_nxt.io_we   = 1'b0;
    state_nxt.io_re   = 1'b0;
    state_nxt.rd_we   = 1'b0;
    state_nxt.sleep   = 1'b0;
    state_nxt.wdog    = 1'b0;
    state_nxt.brk     = 1'b0;
    state_nxt.corrupt = 1'b0;
    state_nxt.lfsr    = {state_r.lfsr[14:0],
                         ^(state_r.lfsr & ssc_pkg::LFSR_TAPS)};

    // Writebacks for reads issued in the previous cycle
    if (state_r.io_re) begin
      state_nxt.rd_we   = 1'b1; // RULE4
      state_nxt.rd_idx  = state_r.io_idx;
      state_nxt.rd_data = io_rdata_i;
    end else if (state_r.mem_re) begin
      state_nxt.rd_we   = 1'b1; // RULE6
      state_nxt.rd_idx  = state_r.pop_idx;
      state_nxt.rd_data = mem_rdata_i;
    end

    if (ptr_load_i) begin
      case (ptr_load_sel_i)
        ssc_pkg::PSEL_Y:  state_nxt.ptr_y = ptr_load_val_i;
        ssc_pkg::PSEL_Z:  state_nxt.ptr_z = ptr_load_val_i;
        ssc_pkg::PSEL_SP: state_nxt.sp    = ptr_load_val_i;
        default: ;
      endcase
    end

    case (state_r.phase)
      ssc_pkg::SSC_PH_READY: begin
        if (take) begin
          state_nxt.hold_wr   = 1'b0;
          state_nxt.hold_rd   = 1'b0;
          state_nxt.hold_data = source_reg_i;
          state_nxt.hold_idx  = op_reg_i;
          case (op_code_i)
            ssc_pkg::SSC_OP_WR_IND: begin
              state_nxt.hold_wr   = 1'b1; // RULE12
              state_nxt.hold_addr = ptr;
            end
            ssc_pkg::SSC_OP_WR_POSTINC: begin
              state_nxt.hold_wr   = 1'b1; // RULE1
              state_nxt.hold_addr = ptr;
              if (op_ptr_z_i) state_nxt.ptr_z = ptr + 16'h0001; // RULE1
              else            state_nxt.ptr_y = ptr + 16'h0001; // RULE1
            end
            ssc_pkg::SSC_OP_WR_PREDEC: begin
              state_nxt.hold_wr   = 1'b1; // RULE2
              state_nxt.hold_addr = ptr - 16'h0001; // RULE2
              if (op_ptr_z_i) state_nxt.ptr_z = ptr - 16'h0001; // RULE2
              else            state_nxt.ptr_y = ptr - 16'h0001; // RULE2
            end
            ssc_pkg::SSC_OP_WR_DIRECT: begin
              state_nxt.hold_wr   = 1'b1; // RULE3
              state_nxt.hold_addr = op_addr_i;
            end
            ssc_pkg::SSC_OP_PUSH: begin
              state_nxt.hold_wr   = 1'b1; // RULE5
              state_nxt.hold_addr = state_r.sp;
              state_nxt.sp        = state_r.sp - 16'h0001;
            end
            ssc_pkg::SSC_OP_POP: begin
              state_nxt.hold_rd   = 1'b1; // RULE6
              state_nxt.hold_addr = state_r.sp + 16'h0001;
              state_nxt.sp        = state_r.sp + 16'h0001;
            end
            ssc_pkg::SSC_OP_IO_READ: begin
              state_nxt.io_re   = 1'b1; // RULE4
              state_nxt.io_addr = op_addr_i[ssc_pkg::IO_AW-1:0];
              state_nxt.io_idx  = op_reg_i;
            end
            ssc_pkg::SSC_OP_IO_WRITE: begin
              state_nxt.io_we    = 1'b1; // RULE4
              state_nxt.io_addr  = op_addr_i[ssc_pkg::IO_AW-1:0];
              state_nxt.io_wdata = source_reg_i;
            end
            ssc_pkg::SSC_OP_SLEEP:        state_nxt.sleep = 1'b1; // RULE7
            ssc_pkg::SSC_OP_WDOG_RESTART: state_nxt.wdog  = 1'b1; // RULE8
            ssc_pkg::SSC_OP_DBG_BREAK:    state_nxt.brk   = 1'b1; // RULE9
            ssc_pkg::SSC_OP_IDLE_OP:      ; // RULE13
            default: ;
          endcase
          if (op_code_i == ssc_pkg::SSC_OP_WR_IND ||
              op_code_i == ssc_pkg::SSC_OP_WR_POSTINC ||
              op_code_i == ssc_pkg::SSC_OP_WR_PREDEC ||
              op_code_i == ssc_pkg::SSC_OP_WR_DIRECT ||
              op_code_i == ssc_pkg::SSC_OP_PUSH ||
              op_code_i == ssc_pkg::SSC_OP_POP) begin
            state_nxt.phase = ssc_pkg::SSC_PH_HOLD;
            state_nxt.busy = 1'b1;
          end
        end
      end
      ssc_pkg::SSC_PH_HOLD: begin
        // Second cycle of a two-cycle operation
        state_nxt.phase    = ssc_pkg::SSC_PH_READY;
        state_nxt.busy     = 1'b0;
        state_nxt.mem_we   = state_r.hold_wr; // RULE1 RULE2 RULE3 RULE5 RULE12
        state_nxt.mem_re   = state_r.hold_rd; // RULE6
        state_nxt.mem_addr = state_r.hold_addr;
        state_nxt.mem_wdata = state_r.hold_data;
        state_nxt.pop_idx  = state_r.hold_idx;
      end
      default: begin
        state_nxt.phase = ssc_pkg::SSC_PH_READY;
        state_nxt.busy  = 1'b0;
      end
    endcase

    // Lock programming, including the corruption fault
    if (lock_wr_i) begin
      state_nxt.lock = lock_mode_i;
      if (lock_mode_i <= state_r.lock) begin
        state_nxt.corrupt      = 1'b1; // RULE10
        state_nxt.corrupt_addr = state_r.lfsr[FLASH_AW-1:0]; // RULE10
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r              <= '0;
      state_r.phase        <= ssc_pkg::SSC_PH_READY;
      state_r.ptr_y        <= ssc_pkg::PTR_RESET;
      state_r.ptr_z        <= ssc_pkg::PTR_RESET;
      state_r.sp           <= ssc_pkg::SP_RESET;
      state_r.lock         <= ssc_pkg::LOCK_RESET;
      state_r.lfsr         <= ssc_pkg::LFSR_SEED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign busy_o               = state_r.busy;
  assign mem_we_o             = state_r.mem_we;
  assign mem_re_o             = state_r.mem_re;
  assign mem_addr_o           = state_r.mem_addr;
  assign mem_wdata_o          = state_r.mem_wdata;
  assign io_we_o              = state_r.io_we;
  assign io_re_o              = state_r.io_re;
  assign io_addr_o            = state_r.io_addr;
  assign io_wdata_o           = state_r.io_wdata;
  assign rd_we_o              = state_r.rd_we;
  assign rd_idx_o             = state_r.rd_idx;
  assign rd_data_o            = state_r.rd_data;
  assign ptr_y_o              = state_r.ptr_y;
  assign ptr_z_o              = state_r.ptr_z;
  assign sp_o                 = state_r.sp;
  assign sleep_req_o          = state_r.sleep;
  assign watchdog_restart_o   = state_r.wdog;
  assign dbg_break_o          = state_r.brk;
  assign lock_mode_o          = state_r.lock;
  assign flash_corrupt_o      = state_r.corrupt;
  assign flash_corrupt_addr_o = state_r.corrupt_addr;

endmodule : ssc_exec

// *** bench/ssc_exec_sva.sv ***
// Port assertions for the store, stack and control executor
`timescale 1ns/1ps
module ssc_exec_sva #(
  parameter int FLASH_AW = ssc_pkg::FLASH_AW
) (
  input wire logic             clock_i,
  input wire logic             srst_i,
  input wire logic             op_valid_i,
  input wire ssc_pkg::ssc_op_t op_code_i,
  input wire logic             op_ptr_z_i,
  input wire logic [15:0]      op_addr_i,
  input wire logic [7:0]       source_reg_i,
  input wire logic [7:0]       mem_rdata_i,
  input wire logic [7:0]       io_rdata_i,
  input wire logic             ptr_load_i,
  input wire logic             lock_wr_i,
  input wire logic [1:0]       lock_mode_i,
  input wire logic             busy_o,
  input wire logic             mem_we_o,
  input wire logic             mem_re_o,
  input wire logic [15:0]      mem_addr_o,
  input wire logic [7:0]       mem_wdata_o,
  input wire logic             io_we_o,
  input wire logic             io_re_o,
  input wire logic [5:0]       io_addr_o,
  input wire logic [7:0]       io_wdata_o,
  input wire logic             rd_we_o,
  input wire logic [7:0]       rd_data_o,
  input wire logic [15:0]      ptr_y_o,
  input wire logic [15:0]      ptr_z_o,
  input wire logic             sleep_req_o,
  input wire logic             watchdog_restart_o,
  input wire logic [1:0]       lock_mode_o,
  input wire logic             flash_corrupt_o,
  input wire logic [FLASH_AW-1:0] flash_corrupt_addr_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic       take;
  logic [3:0] k;
  assign take = op_valid_i && !busy_o && !ptr_load_i;
  // Opcode by enum position
  assign k = op_code_i;
  sequence s_wr2;
    busy_o ##1 (mem_we_o && !busy_o && mem_wdata_o == $past(source_reg_i, 2))
    ##1 !mem_we_o;
  endsequence
  property p_store;
    take && (k inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7}) |=> s_wr2;
  endproperty
  a_store: assert property (p_store)
    else $error("store timing or data wrong");
  property p_postinc;
    take && k == 4'h2 && op_ptr_z_i |=> ptr_z_o == $past(ptr_z_o) + 16'h0001
    ##1 mem_addr_o == $past(ptr_z_o, 2);
  endproperty
  a_postinc: assert property (p_postinc)
    else $error("post-increment store wrong");
  property p_predec;
    take && k == 4'h3 && !op_ptr_z_i |=> ptr_y_o == $past(ptr_y_o) - 16'h0001
    ##1 mem_addr_o == $past(ptr_y_o, 2) - 16'h0001;
  endproperty
  a_predec: assert property (p_predec)
    else $error("pre-decrement store wrong");
  property p_plain;
    take && k == 4'h1 && op_ptr_z_i |=> $stable(ptr_z_o)
    ##1 mem_addr_o == $past(ptr_z_o, 2);
  endproperty
  a_plain: assert property (p_plain)
    else $error("plain store wrong");
  property p_direct;
    take && k == 4'h4 |=> ##1 mem_addr_o == $past(op_addr_i, 2);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct store address wrong");
  property p_pop;
    take && k == 4'h8 |=> busy_o ##1 mem_re_o
    ##1 (rd_we_o && rd_data_o == $past(mem_rdata_i));
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop wrong");
  property p_iord;
    take && k == 4'h5 |=> (io_re_o && io_addr_o == $past(op_addr_i[5:0]))
    ##1 (rd_we_o && rd_data_o == $past(io_rdata_i));
  endproperty
  a_iord: assert property (p_iord)
    else $error("io read wrong");
  property p_iowr;
    take && k == 4'h6 |=> io_we_o && !busy_o
    && io_wdata_o == $past(source_reg_i);
  endproperty
  a_iowr: assert property (p_iowr)
    else $error("io write wrong");
  property p_sleep;
    take && k == 4'h9 |=> sleep_req_o && !busy_o;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep request missing");
  property p_wdog;
    take && k == 4'hA |=> watchdog_restart_o && !busy_o;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog restart missing");
  property p_idle;
    take && k == 4'h0 |=> !busy_o && !mem_we_o && !io_we_o
    && $stable(ptr_y_o) && $stable(ptr_z_o);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle op changed state");
  property p_lock;
    lock_wr_i |=> lock_mode_o == $past(lock_mode_i)
    && flash_corrupt_o == ($past(lock_mode_i) <= $past(lock_mode_o));
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock write wrong");
  // The reported word only moves together with a corruption pulse
  property p_caddr;
    $changed(flash_corrupt_addr_o) |-> flash_corrupt_o;
  endproperty
  a_caddr: assert property (p_caddr)
    else $error("corrupt address moved without a pulse");
endmodule : ssc_exec_sva
bind ssc_exec ssc_exec_sva #(.FLASH_AW(FLASH_AW)) u_sva (
  .clock_i(clock_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
  .op_code_i(op_code_i), .op_ptr_z_i(op_ptr_z_i), .op_addr_i(op_addr_i),
  .source_reg_i(source_reg_i), .mem_rdata_i(mem_rdata_i),
  .io_rdata_i(io_rdata_i), .ptr_load_i(ptr_load_i), .lock_wr_i(lock_wr_i),
  .lock_mode_i(lock_mode_i), .busy_o(busy_o), .mem_we_o(mem_we_o),
  .mem_re_o(mem_re_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .io_we_o(io_we_o), .io_re_o(io_re_o), .io_addr_o(io_addr_o),
  .io_wdata_o(io_wdata_o), .rd_we_o(rd_we_o), .rd_data_o(rd_data_o),
  .ptr_y_o(ptr_y_o), .ptr_z_o(ptr_z_o), .sleep_req_o(sleep_req_o),
  .watchdog_restart_o(watchdog_restart_o), .lock_mode_o(lock_mode_o),
  .flash_corrupt_o(flash_corrupt_o),
  .flash_corrupt_addr_o(flash_corrupt_addr_o)
);

// *** bench/ssc_exec_tb_top.sv ***
// Self-checking bench for the store, stack and control executor
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module ssc_exec_tb_top;
  logic clock_i = 1'b0, srst_i = 1'b1, op_valid_i = 1'b0, op_ptr_z_i = 1'b0;
  logic ptr_load_i = 1'b0, lock_wr_i = 1'b0;
  ssc_pkg::ssc_op_t op_code_i = ssc_pkg::SSC_OP_IDLE_OP;
  logic [3:0]  op_reg_i = 4'h0;
  logic [15:0] op_addr_i = 16'h0000, ptr_load_val_i = 16'h0000;
  logic [7:0]  source_reg_i = 8'h00;
  logic [1:0]  ptr_load_sel_i = 2'h3, lock_mode_i = 2'h0, lock_mode_o;
  logic busy_o, mem_we_o, mem_re_o, io_we_o, io_re_o, rd_we_o;
  logic sleep_req_o, watchdog_restart_o, dbg_break_o, flash_corrupt_o;
  logic [15:0] mem_addr_o, ptr_y_o, ptr_z_o, sp_o;
  logic [7:0]  mem_wdata_o, io_wdata_o, rd_data_o;
  logic [5:0]  io_addr_o;
  logic [3:0]  rd_idx_o;
  logic [8:0]  flash_corrupt_addr_o;
  // Memory and I/O answer combinationally from the address
  wire logic [7:0] mem_rdata_i = mem_addr_o[7:0] ^ 8'h5A;
  wire logic [7:0] io_rdata_i = {2'h0, io_addr_o} ^ 8'hC3;
  int err_count = 0, checked = 0, cyc = 0;
  logic [31:0] rs = 32'h0000D994;
  logic [15:0] y = 16'h0000, z = 16'h0000, sp = ssc_pkg::SP_RESET;
  logic [1:0]  lk = 2'h0;
  logic [26:0] notes[$];
  ssc_exec u_dut (
    .clock_i(clock_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_ptr_z_i(op_ptr_z_i), .op_reg_i(op_reg_i),
    .op_addr_i(op_addr_i), .source_reg_i(source_reg_i),
    .mem_rdata_i(mem_rdata_i), .io_rdata_i(io_rdata_i),
    .ptr_load_i(ptr_load_i), .ptr_load_sel_i(ptr_load_sel_i),
    .ptr_load_val_i(ptr_load_val_i), .lock_wr_i(lock_wr_i),
    .lock_mode_i(lock_mode_i), .busy_o(busy_o), .mem_we_o(mem_we_o),
    .mem_re_o(mem_re_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .io_we_o(io_we_o), .io_re_o(io_re_o), .io_addr_o(io_addr_o),
    .io_wdata_o(io_wdata_o), .rd_we_o(rd_we_o), .rd_idx_o(rd_idx_o),
    .rd_data_o(rd_data_o), .ptr_y_o(ptr_y_o), .ptr_z_o(ptr_z_o),
    .sp_o(sp_o), .sleep_req_o(sleep_req_o),
    .watchdog_restart_o(watchdog_restart_o), .dbg_break_o(dbg_break_o),
    .lock_mode_o(lock_mode_o), .flash_corrupt_o(flash_corrupt_o),
    .flash_corrupt_addr_o(flash_corrupt_addr_o)
  );
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Take the note once; an empty queue yields a value no result can match
  task automatic see(logic [26:0] got);
    logic [26:0] want;
    want = 27'h7FFFFFF;
    if (notes.size() > 0) want = notes.pop_front();
    `CHK(got, want)
  endtask : see
  // Oldest producer first: writebacks land with the next op's pulses
  always @(negedge clock_i) begin
    if (rd_we_o) see({3'h3, 12'h000, rd_idx_o, rd_data_o});
    if (mem_we_o) see({3'h1, mem_addr_o, mem_wdata_o});
    if (io_we_o) see({3'h2, 10'h000, io_addr_o, io_wdata_o});
    if (sleep_req_o | watchdog_restart_o | dbg_break_o)
      see({3'h4, 13'h0000, sleep_req_o, watchdog_restart_o, dbg_break_o,
           8'h00});
    if (flash_corrupt_o) see({3'h5, 22'h000000, lock_mode_o});
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // Called just after an edge; 2-cycle ops stay requested while refused
  task automatic run(logic [3:0] k, logic pz);
    logic [15:0] p, np, w, a;
    logic [7:0]  s, d;
    logic [3:0]  r;
    p = pz ? z : y;
    a = 16'(rnd());
    s = 8'(rnd());
    r = 4'(rnd());
    d = {2'h0, a[5:0]} ^ 8'hC3;
    np = (k == 4'h2) ? p + 16'h0001 : (k == 4'h3) ? p - 16'h0001 : p;
    w = (k == 4'h4) ? a : (k == 4'h7) ? sp : (k == 4'h3) ? np : p;
    sp = (k == 4'h7) ? sp - 16'h0001 : (k == 4'h8) ? sp + 16'h0001 : sp;
    if (k == 4'h8) d = sp[7:0] ^ 8'h5A;
    if (k inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7}) notes.push_back({3'h1, w, s});
    if (k inside {4'h5, 4'h8}) notes.push_back({3'h3, 12'h000, r, d});
    if (k == 4'h6) notes.push_back({3'h2, 10'h000, a[5:0], s});
    if (k > 4'h8) notes.push_back({3'h4, 13'h0000, k == 4'h9, k == 4'hA,
                                   k == 4'hB, 8'h00});
    if (pz) z = np;
    else y = np;
    op_valid_i = 1'b1;
    ptr_load_i = 1'b0;
    op_code_i = ssc_pkg::ssc_op_t'(k);
    op_ptr_z_i = pz;
    op_addr_i = a;
    source_reg_i = s;
    op_reg_i = r;
    @(posedge clock_i);
    #2;
    if (k inside {[4'h1 : 4'h4], 4'h7, 4'h8}) begin
      @(posedge clock_i);
      #2;
    end
    `CHK({ptr_y_o, ptr_z_o, sp_o}, {y, z, sp})
  endtask : run
  task automatic ld(logic [1:0] sel, logic [15:0] v);
    op_valid_i = 1'b0;
    ptr_load_i = 1'b1;
    ptr_load_sel_i = sel;
    ptr_load_val_i = v;
    @(posedge clock_i);
    #2;
    if (sel == 2'h0) y = v;
    else if (sel == 2'h1) z = v;
    else if (sel == 2'h2) sp = v;
  endtask : ld
  task automatic lock(logic [1:0] m);
    op_valid_i = 1'b0;
    lock_wr_i = 1'b1;
    lock_mode_i = m;
    if (m <= lk) notes.push_back({3'h5, 22'h000000, m});
    lk = m;
    @(posedge clock_i);
    #2;
    `CHK(lock_mode_o, lk)
  endtask : lock
  initial begin
    repeat (20) @(posedge clock_i);
    #2;
    srst_i = 1'b0;
    `CHK({ptr_y_o, ptr_z_o, sp_o, lock_mode_o}, {32'h0, sp, 2'h0})
    // Pointer wrap at both ends, every opcode through both pairs
    for (int i = 0; i < 24; i++) begin
      if (i % 12 == 0) ld(2'h0, 16'h0000);
      if (i % 12 == 0) ld(2'h1, 16'hFFFF);
      run(4'(i % 12), 1'(i / 12));
    end
    for (int i = 0; i < 200; i++) begin
      if (rnd() % 8 == 0) ld(2'(rnd()), 16'(rnd()));
      run(4'(rnd() % 12), 1'(rnd()));
    end
    lock(2'h1);
    lock(2'h1);
    lock(2'h3);
    lock(2'h0);
    lock(2'h2);
    lock_wr_i = 1'b0;
    repeat (4) @(posedge clock_i);
    `CHK(notes.size(), 0)
    tally_and_finish();
  end
endmodule : ssc_exec_tb_top
